// ==== remote_port_i2c_ack_usage_bench.sv ====
// Self-checking bench of the port expander with a bus master model.
// Assumes the design's default device address 7'h20.
`timescale 1ns/1ps
module remote_port_i2c_ack_usage_bench;
  // ****
  // Wiring, open-drain resolution, checking
  // ****
  logic            sys_clk, reset, ack;
  logic [7:0]      ext, rd;
  wire logic       scl, m_low, sda_out, sda_oe_n, alert_out, alert_oe_n;
  wire logic [7:0] port_out, port_oe_n;
  wire logic       sda = !m_low && (sda_oe_n || sda_out);
  wire logic [7:0] pins = ext & (port_oe_n | port_out);
  int              n_mismatch = 0;
  int              checks_done = 0;
  int              cyc = 0;
  rpexp_top rpexp_top_inst (.sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .port_in(pins), .port_out(port_out),
    .port_oe_n(port_oe_n), .alert_out(alert_out), .alert_oe_n(alert_oe_n));
  rpexp_master rpexp_master_inst (.scl(scl), .sda_low(m_low), .sda(sda));
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
    #1.25;
  endtask
  task automatic set_ext(input logic [7:0] v);
    @(posedge sys_clk);
    #1.25 ext = v;
    wait_clk(10);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    rpexp_master_inst.start();
    rpexp_master_inst.wbyte({a, 1'b0}, ack);
    check("addr ack", 8'(ack), 8'(a != 7'h20));
    if (!ack) rpexp_master_inst.wbyte(d, ack);
    if (a == 7'h20) check("data ack", 8'(ack), 8'h00);
    rpexp_master_inst.stop();
  endtask
  task automatic rdp(input logic more);
    rpexp_master_inst.start();
    rpexp_master_inst.wbyte({7'h20, 1'b1}, ack);
    check("read addr ack", 8'(ack), 8'h00);
    rpexp_master_inst.rbyte(more, rd);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    wait_clk(4);
    check("port after reset", port_oe_n, 8'hFF);
    check("lines after reset", 8'({sda_oe_n, alert_oe_n}), 8'h03);
    $display("reset test done");
  endtask
  task automatic t_write();
    logic [7:0] tbl [3] = '{8'hA3, 8'h5C, 8'hFF};
    rpexp_master_inst.start();
    rpexp_master_inst.wbyte({7'h20, 1'b0}, ack);
    // Bits 1:0 are set equal in every table byte, so they always move together
    foreach (tbl[i]) begin
      rpexp_master_inst.wbyte(tbl[i], ack);
      check("byte ack", 8'(ack), 8'h00);
      wait_clk(8);
      check("port value", port_oe_n, tbl[i]);
      check("alert after own write", 8'(alert_oe_n), 8'h01);
    end
    rpexp_master_inst.stop();
    $display("write test done");
  endtask
  task automatic t_read();
    wr(7'h20, 8'hF3); // Input bits 7:4 and 1:0 written high
    set_ext(8'h6F);
    rdp(1'b1);
    check("first read", rd, 8'h63);
    rpexp_master_inst.rbyte(1'b0, rd);
    check("last read", rd, 8'h63);
    wait_clk(4);
    check("line after nack", 8'({sda, sda_oe_n}), 8'h03);
    rpexp_master_inst.stop();
    $display("read test done");
  endtask
  task automatic t_alert();
    wait_clk(10);
    check("alert after read", 8'(alert_oe_n), 8'h01);
    set_ext(8'h6E);
    check("alert on change", 8'(alert_oe_n), 8'h00);
    set_ext(8'h6F);
    check("alert on revert", 8'(alert_oe_n), 8'h01);
    set_ext(8'h6E);
    rdp(1'b0);
    rpexp_master_inst.stop();
    check("read new pins", rd, 8'h62);
    wait_clk(10);
    check("alert cleared by read", 8'(alert_oe_n), 8'h01);
    set_ext(8'h6F);
    check("alert again", 8'(alert_oe_n), 8'h00);
    wr(7'h20, 8'hF3);
    wait_clk(10);
    check("alert cleared by write", 8'(alert_oe_n), 8'h01);
    $display("alert test done");
  endtask
  task automatic t_refuse();
    wr(7'h21, 8'h00);
    wait_clk(10);
    check("port kept", port_oe_n, 8'hF3);
    $display("refuse test done");
  endtask
  // ****
  // Clock, timeout, main sequence
  // ****
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    reset = 1'b1;
    ext = 8'hFF;
    repeat (4) @(posedge sys_clk);
    #1.25 reset = 1'b0;
    t_reset();
    t_write();
    t_read();
    t_alert();
    t_refuse();
    close_out();
  end
endmodule

// ==== rpexp_checker.sv ====
// Pin-level checks of the port expander.
// Assumes open-drain lines resolved outside with pull-ups.
`timescale 1ns/1ps
module rpexp_checker #(parameter int PORT_W = 8) (
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire logic              scl_in,
  input wire logic              sda_in,
  input wire logic              sda_out,
  input wire logic              sda_oe_n,
  input wire logic [PORT_W-1:0] port_in,
  input wire logic [PORT_W-1:0] port_out,
  input wire logic [PORT_W-1:0] port_oe_n,
  input wire logic              alert_out,
  input wire logic              alert_oe_n
);
  // ****
  // Cycles since pins or bus clock last moved, saturating
  // ****
  logic [3:0]        pin_age_r, pin_age_nxt, scl_age_r, scl_age_nxt;
  logic [PORT_W-1:0] pin_old_r;
  logic              scl_old_r;
  always_comb begin
    pin_age_nxt = (port_in != pin_old_r) ? 4'h0 : pin_age_r + 4'(pin_age_r != 4'hF);
    scl_age_nxt = (scl_in != scl_old_r) ? 4'h0 : scl_age_r + 4'(scl_age_r != 4'hF);
    if (reset) begin
      pin_age_nxt = 4'h0;
      scl_age_nxt = 4'h0;
    end
  end
  always_ff @(posedge sys_clk) begin
    pin_age_r <= pin_age_nxt;
    scl_age_r <= scl_age_nxt;
    pin_old_r <= port_in;
    scl_old_r <= scl_in;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_OD_ZERO: assert property (sda_out == 1'b0 && port_out == '0 && alert_out == 1'b0)
    else $error("open drain value not zero");
  AST_RST_IDLE: assert property (disable iff (1'b0)
    reset |=> port_oe_n == '1 && sda_oe_n && alert_oe_n) else $error("reset state wrong");
  AST_SDA_SCL_LOW: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data line moved with bus clock high");
  AST_SDA_ONCE: assert property ($changed(sda_oe_n) |=> $stable(sda_oe_n)[*4])
    else $error("data line moved twice in one bit");
  AST_SDA_SYNC: assert property ($changed(sda_oe_n) |-> $past(scl_in) == $past(scl_in, 2))
    else $error("data line answered an unsynchronised clock edge");
  AST_PORT_SCL_LOW: assert property ($changed(port_oe_n) |-> !scl_in)
    else $error("port changed outside acknowledge end");
  AST_ALERT_CAUSE: assert property ($fell(alert_oe_n) |-> pin_age_r <= 4'h8)
    else $error("alert without pin change");
  AST_ALERT_CLEAR: assert property ($rose(alert_oe_n) |-> pin_age_r <= 4'h8 || scl_age_r <= 4'h8)
    else $error("alert cleared without revert or access");
  COV_ACK: cover property ($fell(sda_oe_n));
  COV_ALERT: cover property ($fell(alert_oe_n));
  COV_PORT: cover property ($changed(port_oe_n));
endmodule
bind rpexp_top rpexp_checker #(.PORT_W(PORT_W)) rpexp_checker_inst (
  .sys_clk(sys_clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .port_in(port_in), .port_out(port_out),
  .port_oe_n(port_oe_n), .alert_out(alert_out), .alert_oe_n(alert_oe_n));

// ==== rpexp_defines.svh ====
// Constants of the remote port expander: timing, widths and reset values.
// Assumes it is included by bare name; definitions only.
`ifndef RPEXP_DEFINES_SVH
`define RPEXP_DEFINES_SVH
`define RPEXP_PORT_W        8
`define RPEXP_PORT_RST      8'hFF
`define RPEXP_ADDR_W        7
`define RPEXP_ADDR_DEF      7'h20
`define RPEXP_FIFO_DEPTH    16
`define RPEXP_BIT_CNT_W     4
`define RPEXP_BITS_PER_BYTE 4'h8
`define RPEXP_SETTLE_CYC    2'h3
`endif

// ==== rpexp_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/1ps
module rpexp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic   sys_clk,
  input  wire logic   reset,
  rpexp_fifo_if.sink  in_if,
  rpexp_fifo_if.src   out_if
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r, wp_nxt;
  logic [AW:0]      rp_r, rp_nxt;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full         = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty        = (wp_r == rp_r);
  assign in_if.ready  = !full;
  assign out_if.valid = !empty;
  assign out_if.data  = mem[rp_r[AW-1:0]];
  assign push         = in_if.valid && !full;
  assign pop          = out_if.ready && !empty;

  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_if.data;
    end
  end
endmodule

// ==== rpexp_fifo_if.sv ====
// Valid/ready carrier from the bus engine into the write FIFO and from the FIFO to the port latch.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
interface rpexp_fifo_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src  (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// ==== rpexp_master.sv ====
// Bus master model: makes the bus clock and pulls the data line low.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
module rpexp_master #(parameter int PH = 24) (
  output logic     scl,
  output logic     sda_low,
  input wire logic sda
);
  // ****
  // Bit and byte tasks; clock stands high between frames
  // ****
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    #PH sda_low = !b; // Data moves mid low phase only
    #PH scl = 1'b1;
    #PH r = sda;
    #PH scl = 1'b0;
  endtask
  task automatic start();
    sda_low = 1'b1;
    #(2*PH) scl = 1'b0;
  endtask
  task automatic stop();
    #PH sda_low = 1'b1;
    #PH scl = 1'b1;
    #(2*PH) sda_low = 1'b0;
    #(2*PH);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack); // Released for the receiver
  endtask
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!more, r); // All but the last byte acknowledged
  endtask
endmodule

// ==== rpexp_pkg.sv ====
// Types shared by the remote port expander modules.
// Assumes the defines header sits in the same folder.
`include "rpexp_defines.svh"
package rpexp_pkg;
  // ************************************************************
  // Bus engine states
  // ************************************************************
  typedef enum logic [5:0] {
    RPEXP_IDLE   = 6'h01,
    RPEXP_ADDR   = 6'h02,
    RPEXP_ACK_TX = 6'h04,
    RPEXP_WDATA  = 6'h08,
    RPEXP_RDATA  = 6'h10,
    RPEXP_ACK_RX = 6'h20
  } rpexp_state_t;
endpackage

// ==== rpexp_top.sv ====
// Remote 8-bit quasi-bidirectional port expander behind a two-wire bus slave.
// Assumes bus pins and port pins are asynchronous; sys_clk far faster than bus clock.
`timescale 1ns/1ps
module rpexp_top
  import rpexp_pkg::*;
#(
  parameter int                        PORT_W   = `RPEXP_PORT_W,
  parameter logic [`RPEXP_ADDR_W-1:0]  DEV_ADDR = `RPEXP_ADDR_DEF
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe_n,
  input  wire logic [PORT_W-1:0] port_in,
  output logic      [PORT_W-1:0] port_out,
  output logic      [PORT_W-1:0] port_oe_n,
  output logic                   alert_out,
  output logic                   alert_oe_n
);
  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [PORT_W+1:0] sync1_r;
  logic [PORT_W+1:0] sync2_r;
  logic              scl_s, sda_s, scl_d_r, sda_d_r;
  logic [PORT_W-1:0] pin_s;

  always_ff @(posedge sys_clk) begin
    sync1_r <= {scl_in, sda_in, port_in};
    sync2_r <= sync1_r;
  end
  assign scl_s = sync2_r[PORT_W+1];
  assign sda_s = sync2_r[PORT_W];
  assign pin_s = sync2_r[PORT_W-1:0];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_ev  = scl_s && scl_d_r && !sda_d_r && sda_s;

  // ************************************************************
  // Bus engine
  // ************************************************************
  rpexp_state_t                  st_r, st_nxt;
  logic [PORT_W-1:0]             sh_r, sh_nxt;
  logic [`RPEXP_BIT_CNT_W-1:0]   cnt_r, cnt_nxt;
  logic                          rd_r, rd_nxt;
  logic                          drv_r, drv_nxt;
  logic                          nack_r, nack_nxt;
  logic                          sh_valid_r, sh_valid_nxt;
  logic                          wr_commit;
  logic                          rd_access;

  rpexp_fifo_if #(.WIDTH(PORT_W)) wq_in ();
  rpexp_fifo_if #(.WIDTH(PORT_W)) wq_out ();

  always_comb begin
    st_nxt    = st_r;
    sh_nxt    = sh_r;
    cnt_nxt   = cnt_r;
    rd_nxt    = rd_r;
    drv_nxt   = drv_r;
    nack_nxt  = nack_r;
    wr_commit = 1'b0;
    rd_access = 1'b0;
    if (start_ev) begin
      st_nxt  = RPEXP_ADDR;
      cnt_nxt = '0;
      drv_nxt = 1'b0;
    end else if (stop_ev) begin
      st_nxt  = RPEXP_IDLE;
      drv_nxt = 1'b0;
    end else begin
      case (st_r)
        RPEXP_IDLE: begin
          drv_nxt = 1'b0;
        end
        RPEXP_ADDR, RPEXP_WDATA: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[PORT_W-2:0], sda_s};
            cnt_nxt = cnt_r + 1'b1;
          end else if (scl_fall && cnt_r == `RPEXP_BITS_PER_BYTE) begin
            cnt_nxt = '0;
            if (st_r == RPEXP_ADDR && sh_r[PORT_W-1:1] != DEV_ADDR) begin
              st_nxt = RPEXP_IDLE;
            end else if (st_r == RPEXP_WDATA && !wq_in.ready) begin
              st_nxt = RPEXP_IDLE; // Full queue: byte refused with no acknowledge
            end else begin
              if (st_r == RPEXP_ADDR) begin
                rd_nxt = sh_r[0];
              end
              st_nxt  = RPEXP_ACK_TX;
              drv_nxt = 1'b1;
            end
          end
        end
        RPEXP_ACK_TX: begin
          if (scl_fall) begin
            drv_nxt = 1'b0;
            if (rd_r) begin
              sh_nxt    = pin_s;
              rd_access = 1'b1;
              drv_nxt   = !pin_s[PORT_W-1];
              cnt_nxt   = 4'h1;
              st_nxt    = RPEXP_RDATA;
            end else begin
              st_nxt = RPEXP_WDATA;
            end
            wr_commit = !rd_r && st_r == RPEXP_ACK_TX && cnt_r == '0 && sh_valid_r;
          end
        end
        RPEXP_RDATA: begin
          if (scl_fall) begin
            if (cnt_r == `RPEXP_BITS_PER_BYTE) begin
              drv_nxt = 1'b0;
              st_nxt  = RPEXP_ACK_RX;
            end else begin
              sh_nxt  = {sh_r[PORT_W-2:0], 1'b0};
              drv_nxt = !sh_r[PORT_W-2];
              cnt_nxt = cnt_r + 1'b1;
            end
          end
        end
        RPEXP_ACK_RX: begin
          if (scl_rise) begin
            nack_nxt = sda_s;
          end else if (scl_fall) begin
            if (nack_r) begin
              st_nxt  = RPEXP_IDLE;
              drv_nxt = 1'b0;
            end else begin
              sh_nxt    = pin_s;
              rd_access = 1'b1;
              drv_nxt   = !pin_s[PORT_W-1];
              cnt_nxt   = 4'h1;
              st_nxt    = RPEXP_RDATA;
            end
          end
        end
        default: begin
          st_nxt  = RPEXP_IDLE;
          drv_nxt = 1'b0;
        end
      endcase
    end
  end

  // Write data byte is known valid once acknowledged in the data phase
  always_comb begin
    sh_valid_nxt = sh_valid_r;
    if (start_ev || stop_ev) begin
      sh_valid_nxt = 1'b0;
    end else if (st_r == RPEXP_WDATA && st_nxt == RPEXP_ACK_TX) begin
      sh_valid_nxt = 1'b1;
    end else if (st_r == RPEXP_ADDR && st_nxt == RPEXP_ACK_TX) begin
      sh_valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r       <= RPEXP_IDLE;
      sh_r       <= '0;
      cnt_r      <= '0;
      rd_r       <= 1'b0;
      drv_r      <= 1'b0;
      nack_r     <= 1'b1;
      sh_valid_r <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      sh_r       <= sh_nxt;
      cnt_r      <= cnt_nxt;
      rd_r       <= rd_nxt;
      drv_r      <= drv_nxt;
      nack_r     <= nack_nxt;
      sh_valid_r <= sh_valid_nxt;
    end
  end

  // Open drain: the line is only ever pulled low, released otherwise
  assign sda_out  = 1'b0;
  assign sda_oe_n = !drv_r;

  // ************************************************************
  // Write queue and port latch
  // ************************************************************
  // Bytes enter the queue only at the end of their acknowledge bit
  assign wq_in.valid = wr_commit;
  assign wq_in.data  = sh_r;

  rpexp_fifo #(.WIDTH(PORT_W), .DEPTH(`RPEXP_FIFO_DEPTH)) rpexp_fifo_inst (
    .sys_clk (sys_clk),
    .reset   (reset),
    .in_if   (wq_in),
    .out_if  (wq_out)
  );

  logic [PORT_W-1:0] latch_r, latch_nxt;
  logic              wr_apply;
  assign wq_out.ready = 1'b1;
  assign wr_apply     = wq_out.valid;

  always_comb begin
    latch_nxt = wr_apply ? wq_out.data : latch_r;
  end

  // Quasi-bidirectional: a one releases the pin to the weak pull-up
  assign port_out  = '0;
  assign port_oe_n = latch_r;

  // ************************************************************
  // Change alert
  // ************************************************************
  logic [PORT_W-1:0] ref_r, ref_nxt;
  logic              alert_r, alert_nxt;
  logic [1:0]        settle_r, settle_nxt;

  // Own writes move the pins; the reference is re-taken until they pass the synchroniser.
  // Limitation: an outside change inside that short window raises no alert.
  always_comb begin
    ref_nxt    = ref_r;
    alert_nxt  = alert_r;
    settle_nxt = settle_r;
    if (wr_apply) begin
      settle_nxt = `RPEXP_SETTLE_CYC;
    end else if (settle_r != 2'h0) begin
      settle_nxt = settle_r - 2'h1;
    end
    if (rd_access || wr_apply || settle_r != 2'h0) begin
      ref_nxt   = pin_s;
      alert_nxt = 1'b0;
    end else begin
      alert_nxt = (pin_s != ref_r);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      latch_r <= `RPEXP_PORT_RST;
      ref_r   <= `RPEXP_PORT_RST;
      alert_r  <= 1'b0;
      settle_r <= 2'h0;
    end else begin
      latch_r  <= latch_nxt;
      ref_r    <= ref_nxt;
      alert_r  <= alert_nxt;
      settle_r <= settle_nxt;
    end
  end

  // Alert is an open-drain active low line
  assign alert_out  = 1'b0;
  assign alert_oe_n = !alert_r;
endmodule
